// ==== core/serial_ctrl_bus_port.v ====
// Host bus port: register decode, command/pointer handling and byte lanes
`timescale 1ns/1ps
`include "serial_ctrl_bus_port_regs.vh"
module serial_ctrl_bus_port (
    // Clock and reset
    input wire clock,
    input wire arst_n,
    // Host bus pins
    input wire ce_n,
    input wire rd_n,
    input wire wr_n,
    input wire as_n,
    input wire section_select,
    input wire channel_select,
    input wire [15:0] muxed_addr_data_lines,
    output reg [15:0] bus_out,
    output reg bus_oe,
    // Configuration and DMA state
    input wire muxed_mode,
    input wire dma_master,
    // Register side toward the channel cores
    input wire [7:0] rd_byte,
    output reg [4:0] reg_addr,
    output reg to_dma,
    output reg to_channel_a,
    output reg reg_wr,
    output reg reg_rd,
    output reg [7:0] wr_byte,
    // Command/pointer decode
    output reg cmd_strobe,
    output reg [2:0] cmd_code,
    output reg crc_strobe,
    output reg [1:0] crc_code,
    output reg [7:0] command_pointer_reg,
    output reg [7:0] bus_config_reg,
    output reg config_done,
    output reg pointer_armed,
    // DMA master data path
    input wire [7:0] dma_wr_byte,
    input wire dma_drive,
    input wire dma_capture,
    input wire dma_addr0,
    output reg [7:0] dma_rd_byte,
    output reg dma_rd_valid
);
    wire [5:0] ctrl_f;
    wire [15:0] ad_f;
    wire ce_f;
    wire rd_f;
    wire wr_f;
    wire as_f;
    wire sect_f;
    wire chan_f;
    wire rd_act;
    wire wr_act;
    wire rd_start;
    wire wr_start;
    wire wr_end;
    wire as_end;
    wire serial_shift_right;
    wire dma_shift_right;
    wire take_upper;
    reg rd_act_q;
    reg wr_act_q;
    reg as_q;
    reg [4:0] latched_addr;
    reg [3:0] pointer;
    reg next_is_dma;
    reg [4:0] next_addr;

    // Every host pin crosses into the clock domain through the filter
    pin_filter #(
        .WIDTH(6),
        .RESET_VAL(`PIN_CTRL_RESET)
    ) ctrl_sync (
        .clock(clock),
        .arst_n(arst_n),
        .pin({ce_n, rd_n, wr_n, as_n, section_select, channel_select}),
        .level(ctrl_f)
    );

    pin_filter #(
        .WIDTH(16),
        .RESET_VAL(`PIN_DATA_RESET)
    ) data_sync (
        .clock(clock),
        .arst_n(arst_n),
        .pin(muxed_addr_data_lines),
        .level(ad_f)
    );

    assign ce_f = ctrl_f[5];
    assign rd_f = ctrl_f[4];
    assign wr_f = ctrl_f[3];
    assign as_f = ctrl_f[2];
    assign sect_f = ctrl_f[1];
    assign chan_f = ctrl_f[0];

    // Slave strobes are ignored while the DMA section owns the bus
    assign rd_act = ~ce_f & ~rd_f & ~dma_master;
    assign wr_act = ~ce_f & ~wr_f & ~dma_master;
    assign rd_start = rd_act & ~rd_act_q;
    assign wr_start = wr_act & ~wr_act_q;
    assign wr_end = ~wr_act & wr_act_q;
    assign as_end = as_f & ~as_q;

    // Shift modes of the two sections are held apart
    assign serial_shift_right = (command_pointer_reg[`CP_SHIFT_MSB:`CP_SHIFT_LSB]
        == `CP_SHIFT_RIGHT); // RULE2
    assign dma_shift_right = (bus_config_reg[`BCR_SHIFT_BIT] == `BCR_SHIFT_RIGHT); // RULE3

    // Lane choice for bytes fetched from memory
    assign take_upper = bus_config_reg[`BCR_SWAP_EN_BIT]
        & (bus_config_reg[`BCR_SWAP_SEL_BIT] ? dma_addr0 : ~dma_addr0); // RULE13

    // Edge history of the filtered strobes
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
            as_q <= 1'b1;
        end else begin
            rd_act_q <= rd_act;
            wr_act_q <= wr_act;
            as_q <= as_f;
        end
    end

    // Multiplexed address latch at the end of address strobe
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            latched_addr <= 5'h00;
        end else if (as_end && muxed_mode) begin
            if (sect_f ? serial_shift_right : dma_shift_right) begin // RULE1 RULE3
                latched_addr <= ad_f[4:0];
            end else begin
                latched_addr <= ad_f[5:1];
            end
        end
    end

    // Target register of the access that is starting
    always @* begin
        next_is_dma = ~sect_f; // RULE14
        next_addr = 5'h00;
        if (muxed_mode) begin
            next_addr = latched_addr; // RULE1
        end else if (!next_is_dma && pointer_armed) begin
            next_addr = {1'b0, pointer}; // RULE4
        end
    end

    // Register side strobes, selection and write byte
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            reg_addr <= 5'h00;
            to_dma <= 1'b0;
            to_channel_a <= 1'b0;
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            wr_byte <= 8'h00;
        end else begin
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            if (rd_start || wr_start) begin
                reg_addr <= next_addr;
                to_dma <= next_is_dma; // RULE14
                to_channel_a <= ~next_is_dma & chan_f; // RULE14
            end
            if (rd_start) begin
                reg_rd <= 1'b1;
            end
            // Writes before configuration are dropped; the first DMA-section write goes to bus configuration
            if (wr_end && config_done) begin
                reg_wr <= 1'b1;
                wr_byte <= ad_f[7:0]; // RULE9 RULE7
            end
        end
    end

    // Command/pointer register, pointer and bus configuration
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            command_pointer_reg <= `CP_RESET;
            bus_config_reg <= `BCR_RESET;
            config_done <= 1'b0;
            pointer_armed <= 1'b0;
            pointer <= 4'h0;
            cmd_strobe <= 1'b0;
            cmd_code <= `CMD_NULL;
            crc_strobe <= 1'b0;
            crc_code <= `CRC_NULL;
        end else begin
            cmd_strobe <= 1'b0;
            crc_strobe <= 1'b0;
            if (wr_end && !config_done) begin
                if (!to_dma) begin
                    config_done <= 1'b0;
                end else begin
                    bus_config_reg <= ad_f[7:0]; // RULE3
                    config_done <= 1'b1;
                end
            end else if (wr_end && !to_dma && reg_addr == 5'h00 && !pointer_armed) begin
                // Write lands in the command/pointer register
                command_pointer_reg <= ad_f[7:0];
                if (ad_f[`CP_CMD_MSB:`CP_CMD_LSB] != `CMD_NULL) begin
                    cmd_strobe <= 1'b1; // RULE5
                    cmd_code <= ad_f[`CP_CMD_MSB:`CP_CMD_LSB]; // RULE5
                end
                if (ad_f[`CP_CRC_MSB:`CP_CRC_LSB] != `CRC_NULL) begin
                    crc_strobe <= 1'b1; // RULE6
                    crc_code <= ad_f[`CP_CRC_MSB:`CP_CRC_LSB]; // RULE6
                end
                if (!muxed_mode) begin
                    pointer <= {ad_f[`CP_CMD_MSB:`CP_CMD_LSB] == `CMD_UPPER_BANK,
                        ad_f[`CP_PTR_MSB:`CP_PTR_LSB]}; // RULE4
                    pointer_armed <= 1'b1;
                end
            end else if ((wr_end || rd_start) && pointer_armed && !next_is_dma) begin
                // Second access of the pair sends the pointer home
                pointer_armed <= 1'b0; // RULE12
                pointer <= 4'h0; // RULE12
            end
        end
    end

    // Bus drive: slave read data or DMA write data, byte copied on both lanes
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            bus_out <= 16'h0000;
            bus_oe <= 1'b0;
        end else if (dma_master) begin
            bus_out <= {dma_wr_byte, dma_wr_byte}; // RULE10 RULE7
            bus_oe <= dma_drive;
        end else begin
            bus_out <= {rd_byte, rd_byte}; // RULE8 RULE7
            bus_oe <= rd_act;
        end
    end

    // Byte fetched from memory while DMA master
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            dma_rd_byte <= 8'h00;
            dma_rd_valid <= 1'b0;
        end else begin
            dma_rd_valid <= dma_capture & dma_master;
            if (dma_capture && dma_master) begin
                dma_rd_byte <= take_upper ? ad_f[15:8] : ad_f[7:0]; // RULE11 RULE13
            end
        end
    end
endmodule

// ==== core/serial_ctrl_bus_port_regs.vh ====
// Constants for the host bus port of the two-channel serial controller
//
// Behaviour
// RULE1: Muxed mode: serial registers addressed from lines 5..1 or 4..0.
// RULE2: Serial shift mode comes from command/pointer bits 1..0, independent of DMA.
// RULE3: DMA shift mode comes from bus config bit 0.
// RULE4: Non-muxed: pointer bits 2..0 pick registers 0-7, with upper-bank 8-15.
// RULE5: Command bits 5..3 decode eight commands, null through reset highest in-service.
// RULE6: Bits 7..6 decode null, reset rx CRC, reset tx CRC, reset underrun latch.
// RULE7: Every transfer on the 16-bit bus is a single byte.
// RULE8: Slave reads drive the byte on low lanes and copy it to high lanes.
// RULE9: Slave writes take data from the low byte lanes only.
// RULE10: DMA writes to memory drive the byte on both byte lanes.
// RULE11: DMA reads without byte swap take the low byte lanes only.
// RULE12: Non-muxed pointer returns to zero after the second access of a pair.
// RULE13: Byte swap on: select 1 puts odd bytes high, select 0 reverses lanes.
// RULE14: Section select high picks a serial channel by channel select, low picks DMA.
`ifndef SERIAL_CTRL_BUS_PORT_REGS_VH
`define SERIAL_CTRL_BUS_PORT_REGS_VH

// Command/pointer register fields
`define CP_RESET 8'h00
`define CP_PTR_MSB 2
`define CP_PTR_LSB 0
`define CP_CMD_MSB 5
`define CP_CMD_LSB 3
`define CP_CRC_MSB 7
`define CP_CRC_LSB 6
`define CP_SHIFT_MSB 1
`define CP_SHIFT_LSB 0
`define CP_SHIFT_RIGHT 2'h3

// Command codes in bits 5..3
`define CMD_NULL 3'h0
`define CMD_UPPER_BANK 3'h1
`define CMD_RESET_EXT_STATUS 3'h2
`define CMD_SEND_ABORT 3'h3
`define CMD_INT_NEXT_RX 3'h4
`define CMD_RESET_TX_INT 3'h5
`define CMD_ERROR_RESET 3'h6
`define CMD_RESET_IN_SERVICE 3'h7

// CRC codes in bits 7..6
`define CRC_NULL 2'h0
`define CRC_RESET_RX_CHECKER 2'h1
`define CRC_RESET_TX_GENERATOR 2'h2
`define CRC_RESET_UNDERRUN_EOM 2'h3

// Bus configuration register fields
`define BCR_RESET 8'h00
`define BCR_SHIFT_BIT 0
`define BCR_SHIFT_RIGHT 1'h1
`define BCR_SWAP_EN_BIT 6
`define BCR_SWAP_SEL_BIT 7

// Pin synchroniser reset levels: ce_n, rd_n, wr_n, as_n idle high
`define PIN_CTRL_RESET 6'h3C
`define PIN_DATA_RESET 16'h0000

`endif

// ==== core/pin_filter.v ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_filter #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    // Clock and reset
    input wire clock,
    input wire arst_n,
    // Raw pins and filtered result
    input wire [WIDTH-1:0] pin,
    output reg [WIDTH-1:0] level
);
    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    reg [WIDTH-1:0] stage3;
    wire [WIDTH-1:0] differ;

    // A bit moves only once stages two and three agree
    assign differ = stage2 ^ stage3;

    // Stage one feeds stage two only, to keep metastability contained
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            stage1 <= RESET_VAL;
            stage2 <= RESET_VAL;
            stage3 <= RESET_VAL;
            level <= RESET_VAL;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            level <= (stage3 & ~differ) | (level & differ);
        end
    end
endmodule

// ==== test/bus_port_monitor.sv ====
// Concurrent checks on the host bus port outputs
`timescale 1ns/1ps
module bus_port_monitor (
    // Clock and reset
    input wire clock,
    input wire arst_n,
    // Pins and core inputs
    input wire section_select,
    input wire channel_select,
    input wire dma_master,
    input wire dma_capture,
    input wire [7:0] rd_byte,
    // Outputs watched
    input wire [15:0] bus_out,
    input wire bus_oe,
    input wire reg_rd,
    input wire reg_wr,
    input wire to_dma,
    input wire to_channel_a,
    input wire cmd_strobe,
    input wire [2:0] cmd_code,
    input wire crc_strobe,
    input wire [1:0] crc_code,
    input wire [7:0] command_pointer_reg,
    input wire dma_rd_valid
);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    // Lanes, read path and capture timing
    lane_mirror_a:
        assert property (bus_oe |-> bus_out[15:8] == bus_out[7:0]) else $error("lanes differ");
    read_track_a:
        assert property (bus_oe && $past(bus_oe) && !$past(dma_master)
            |-> bus_out[7:0] == $past(rd_byte)) else $error("read byte lost");
    capture_pulse_a:
        assert property (dma_rd_valid == $past(dma_capture && dma_master))
            else $error("capture late");
    // Command decode agrees with the stored byte, never null
    cmd_code_a:
        assert property (cmd_strobe |-> cmd_code == command_pointer_reg[5:3]
            && cmd_code != 3'h0) else $error("bad command");
    crc_code_a:
        assert property (crc_strobe |-> crc_code == command_pointer_reg[7:6]
            && crc_code != 2'h0) else $error("bad crc code");
    // Routing follows the select pins
    route_chan_a:
        assert property ((reg_rd || reg_wr) && section_select
            |-> !to_dma && to_channel_a == channel_select) else $error("bad channel");
    route_dma_a:
        assert property ((reg_rd || reg_wr) && !section_select |-> to_dma) else $error("not dma");
    // A strobe moves one byte; the next cannot follow within three cycles
    one_byte_a:
        assert property ((reg_rd || reg_wr) |=> !(reg_rd || reg_wr) [*3]) else $error("extra byte");
    cover property (cmd_strobe && crc_strobe);
    cover property (reg_rd && to_dma);
    cover property (dma_rd_valid);
endmodule

// ==== test/mem_partner.sv ====
// System memory answering reads while the device owns the bus
`timescale 1ns/1ps
module mem_partner #(
    parameter [15:0] WORD = 16'h6C93
) (
    // Bus ownership
    input wire dma_master,
    input wire bus_oe,
    // Data lines toward the device
    output wire [15:0] data
);
    // Even byte low, odd byte high; released lines show the inverse
    assign data = (dma_master && !bus_oe) ? WORD : ~WORD;
endmodule

// ==== test/serial_ctrl_bus_port_tb.sv ====
// Self-checking bench for the host bus port
`timescale 1ns/1ps
module serial_ctrl_bus_port_tb;
    localparam [15:0] MEM = 16'h6C93;
    reg clock = 0, arst_n = 0, ce_n = 1, rd_n = 1, wr_n = 1, as_n = 1;
    reg section_select = 0, channel_select = 0, muxed_mode = 0, dma_master = 0;
    reg dma_drive = 0, dma_capture = 0, dma_addr0 = 0;
    reg [7:0] rd_byte = 0, dma_wr_byte = 0, b, e;
    reg [15:0] host_data = 0, s_bo;
    wire [15:0] mem_data, muxed_addr_data_lines, bus_out;
    wire bus_oe, to_dma, to_channel_a, reg_wr, reg_rd, cmd_strobe, crc_strobe;
    wire config_done, pointer_armed, dma_rd_valid;
    wire [4:0] reg_addr;
    wire [2:0] cmd_code;
    wire [1:0] crc_code;
    wire [7:0] wr_byte, command_pointer_reg, bus_config_reg, dma_rd_byte;
    reg s_wr, s_cmd, s_crc, s_a, s_dma;
    reg [2:0] s_cc;
    reg [1:0] s_rc;
    reg [4:0] s_addr;
    reg [7:0] s_wb;
    integer failures = 0, compares = 0, i, j;

    serial_ctrl_bus_port i_dut (
        .clock(clock),
        .arst_n(arst_n),
        .ce_n(ce_n),
        .rd_n(rd_n),
        .wr_n(wr_n),
        .as_n(as_n),
        .section_select(section_select),
        .channel_select(channel_select),
        .muxed_addr_data_lines(muxed_addr_data_lines),
        .bus_out(bus_out),
        .bus_oe(bus_oe),
        .muxed_mode(muxed_mode),
        .dma_master(dma_master),
        .rd_byte(rd_byte),
        .reg_addr(reg_addr),
        .to_dma(to_dma),
        .to_channel_a(to_channel_a),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .wr_byte(wr_byte),
        .cmd_strobe(cmd_strobe),
        .cmd_code(cmd_code),
        .crc_strobe(crc_strobe),
        .crc_code(crc_code),
        .command_pointer_reg(command_pointer_reg),
        .bus_config_reg(bus_config_reg),
        .config_done(config_done),
        .pointer_armed(pointer_armed),
        .dma_wr_byte(dma_wr_byte),
        .dma_drive(dma_drive),
        .dma_capture(dma_capture),
        .dma_addr0(dma_addr0),
        .dma_rd_byte(dma_rd_byte),
        .dma_rd_valid(dma_rd_valid)
    );
    mem_partner #(.WORD(MEM)) i_mem (
        .dma_master(dma_master),
        .bus_oe(bus_oe),
        .data(mem_data)
    );
    // Host owns the lines unless the device is master
    assign muxed_addr_data_lines = dma_master ? mem_data : host_data;

    initial forever #12.5 clock = ~clock;

    task chk(input [23:0] got, input [23:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task summarize;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // One cycle; single-cycle pulses are latched here so none is missed
    task tick;
        @(posedge clock);
        #1;
        if (reg_wr || reg_rd) {s_addr, s_a, s_dma} = {reg_addr, to_channel_a, to_dma};
        if (reg_wr) {s_wr, s_wb} = {1'b1, wr_byte};
        if (cmd_strobe) {s_cmd, s_cc} = {1'b1, cmd_code};
        if (crc_strobe) {s_crc, s_rc} = {1'b1, crc_code};
        if (bus_oe) s_bo = bus_out;
    endtask

    // One host access; pins stand well past the four-flop filter delay
    task acc(input w, input sel, input [15:0] adr, input [15:0] d);
        {s_wr, s_cmd, s_crc, s_a, s_dma, s_addr, s_bo} = 0;
        section_select = sel;
        if (muxed_mode) begin
            host_data = adr;
            as_n = 0;
            repeat (5) tick;
            as_n = 1;
            repeat (5) tick;
        end
        host_data = d;
        {ce_n, wr_n, rd_n} = {1'b0, !w, w};
        repeat (8) tick;
        {ce_n, wr_n, rd_n} = 3'h7;
        repeat (5) tick;
        host_data = ~d;
        repeat (5) tick;
    endtask

    // Reset, then the first DMA-section write lands in the bus configuration register
    task setup(input [7:0] v);
        arst_n = 0;
        muxed_mode = 0;
        repeat (3) tick;
        arst_n = 1;
        tick;
        chk({command_pointer_reg, bus_config_reg, config_done}, 0);
        // A first write aimed at a serial channel must not take the configuration
        acc(1, 1, 0, {8'h00, ~v});
        chk({s_wr, s_cmd, s_crc, config_done, bus_config_reg}, 0);
        acc(1, 0, 0, {8'hFF, v});
        chk({s_wr, config_done, bus_config_reg}, {2'b01, v});
    endtask

    initial begin
        setup(8'hC1);
        channel_select = 1;
        // Every command and CRC code, each followed by a read through the pointer
        for (i = 0; i < 8; i = i + 1) begin
            acc(1, 1, 0, {i[1:0], i[2:0], (i == 1) ? 3'h5 : 3'h0});
            chk({s_cmd, s_crc}, {i != 0, i[1:0] != 0});
            if (i != 0) chk(s_cc, i[2:0]);
            if (i[1:0] != 0) chk(s_rc, i[1:0]);
            rd_byte = 8'hA5 ^ i[7:0];
            acc(0, 1, 0, 0);
            chk({s_a, s_addr}, {1'b1, (i == 1) ? 5'h0D : 5'h00});
            chk(s_bo, {2{rd_byte}});
        end
        // Channel B write through the pointer, junk on the high lanes
        channel_select = 0;
        acc(1, 1, 0, 16'h0003);
        chk(pointer_armed, 1);
        acc(1, 1, 0, 16'hFF5A);
        chk({s_wr, s_a, s_addr, s_wb}, {2'b10, 5'h03, 8'h5A});
        chk(pointer_armed, 0);
        acc(0, 1, 0, 0);
        chk(s_addr, 5'h00);
        // Muxed decode: serial right then left, the DMA section stays right
        muxed_mode = 1;
        acc(1, 1, 0, 16'h0003);
        chk({command_pointer_reg, pointer_armed}, {8'h03, 1'b0});
        acc(0, 1, 16'h0013, 0);
        chk(s_addr, 5'h13);
        acc(1, 1, 0, 16'h0000);
        acc(0, 1, 16'h0026, 0);
        chk(s_addr, 5'h13);
        acc(0, 0, 16'h0013, 0);
        chk({s_dma, s_addr}, {1'b1, 5'h13});
        // Device as master: each lane setting, both parities, then a write
        for (i = 0; i < 3; i = i + 1) begin
            b = (i == 0) ? 8'h01 : (i == 1) ? 8'h41 : 8'hC1;
            setup(b);
            dma_master = 1;
            for (j = 0; j < 2; j = j + 1) begin
                dma_addr0 = j[0];
                repeat (6) tick;
                dma_capture = 1;
                tick;
                dma_capture = 0;
                e = (b[6] && (b[7] ~^ j[0])) ? MEM[15:8] : MEM[7:0];
                chk({dma_rd_valid, dma_rd_byte}, {1'b1, e});
            end
            dma_wr_byte = 8'h3C ^ b;
            dma_drive = 1;
            repeat (4) tick;
            chk({bus_oe, bus_out}, {1'b1, {2{dma_wr_byte}}});
            dma_drive = 0;
            repeat (4) tick;
            dma_master = 0;
        end
        summarize;
    end

    // Cut a hang short well after the expected run length
    initial begin
        #(25 * 5000);
        failures = failures + 1;
        summarize;
    end
endmodule

bind serial_ctrl_bus_port bus_port_monitor i_mon (
    .clock(clock),
    .arst_n(arst_n),
    .section_select(section_select),
    .channel_select(channel_select),
    .dma_master(dma_master),
    .dma_capture(dma_capture),
    .rd_byte(rd_byte),
    .bus_out(bus_out),
    .bus_oe(bus_oe),
    .reg_rd(reg_rd),
    .reg_wr(reg_wr),
    .to_dma(to_dma),
    .to_channel_a(to_channel_a),
    .cmd_strobe(cmd_strobe),
    .cmd_code(cmd_code),
    .crc_strobe(crc_strobe),
    .crc_code(crc_code),
    .command_pointer_reg(command_pointer_reg),
    .dma_rd_valid(dma_rd_valid)
);
